// ==== verilog/spms_pkg.sv ====
// package: constants, types and state layout of the spi master/slave block
package spms_pkg;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int BIT_CNT_W = 4;
   localparam int DIV_W = 8;
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
   localparam logic RST_MASTER = 1'b0;

   // ----------------------------------------------------------------
   // timing: master shift clock half period
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCK_HALF_NS = 20;
   localparam int SCK_HALF_CYC =
      (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic {
      ST_IDLE,
      ST_SHIFT
   } spms_phase_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss;
   } spms_pins_t;

   typedef struct packed {
      spms_pins_t sync1_ff;
      spms_pins_t sync2_ff;
      logic prev_sck_ff;
      logic prev_ss_ff;
      logic master_ff;
      spms_phase_t phase_ff;
      logic [DATA_W-1:0] shreg_ff;
      logic rx_bit_ff;
      logic [BIT_CNT_W-1:0] bitcnt_ff;
      logic [DIV_W-1:0] div_ff;
      logic sck_ff;
      logic [DATA_W-1:0] rx_buf_ff;
      logic rx_full_ff;
      logic flag_ff;
      logic overrun_ff;
   } spms_state_t;

endpackage

// ==== verilog/spms_core.sv ====
// spi master/slave core with pin direction overrides and slave select
`timescale 1ns/100ps
// Summary of operation
// - a new byte is taken for sending only while no shift is running.
// - one received byte is held while the next shifts in; an unread byte is overwritten and overrun is flagged.
// - when enabled, a master forces miso to input, a slave forces mosi, sck and ss to input.
// - a master with ss set as output drives it as plain gpio with no effect on the core.
// - ss pulled low on a master with ss as input clears the master bit and the core becomes slave.
// - such a demotion sets the transfer complete flag, which raises irq when both enables are set.
// - after a demotion master mode stays off until software sets the master bit again.
// - interrupt software should check the master bit is still set, so it is shown on a port.
// - in slave mode the ss pin is always an input.
// - a slave with ss low is active and drives miso only if software made it an output.
// - a slave with ss high keeps all pins as inputs and ignores serial data.
// - ss rising in a slave transfer resets the shifter at once and drops both partial bytes.
module spms_core #(
   parameter int SCK_HALF = spms_pkg::SCK_HALF_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // control
   input wire logic spi_en,
   input wire logic spi_ie,
   input wire logic global_ie,
   input wire logic lsb_first,
   input wire logic master_set,
   input wire spms_pkg::spms_pins_t pin_dir,
   input wire spms_pkg::spms_pins_t pin_gpio,
   // transmit byte
   input wire logic wr_valid,
   input wire logic [spms_pkg::DATA_W-1:0] wr_data,
   output logic wr_ready,
   // receive byte
   input wire logic rd_en,
   output logic [spms_pkg::DATA_W-1:0] rd_data,
   output logic rx_full,
   // status
   input wire logic flag_clr,
   output logic master_select_bit,
   output logic transfer_complete_flag,
   output logic overrun,
   output logic busy,
   output logic irq,
   // link pins
   input wire spms_pkg::spms_pins_t pin_in,
   output spms_pkg::spms_pins_t pin_out,
   output spms_pkg::spms_pins_t pin_oe
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   spms_pkg::spms_state_t q_ff;
   spms_pkg::spms_state_t nxt_q;

   logic ss_low;
   logic demote;
   logic slave_act;
   logic sck_rise;
   logic sck_fall;
   logic ss_rise;
   logic done;
   logic [spms_pkg::DATA_W-1:0] shifted;

   localparam logic [spms_pkg::DIV_W-1:0] DIV_LAST =
      spms_pkg::DIV_W'(SCK_HALF - 1);

   // ----------------------------------------------------------------
   // decoded conditions
   // ----------------------------------------------------------------
   assign ss_low = ~q_ff.sync2_ff.ss;
   assign demote = spi_en & q_ff.master_ff & ~pin_dir.ss & ss_low;
   assign slave_act = spi_en & ~q_ff.master_ff & ss_low;
   assign sck_rise = q_ff.sync2_ff.sck & ~q_ff.prev_sck_ff;
   assign sck_fall = ~q_ff.sync2_ff.sck & q_ff.prev_sck_ff;
   assign ss_rise = q_ff.sync2_ff.ss & ~q_ff.prev_ss_ff;

   always_comb begin
      if (lsb_first) begin
         shifted = {q_ff.rx_bit_ff, q_ff.shreg_ff[spms_pkg::DATA_W-1:1]};
      end else begin
         shifted = {q_ff.shreg_ff[spms_pkg::DATA_W-2:0], q_ff.rx_bit_ff};
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_q = q_ff;
      done = 1'b0;
      nxt_q.sync1_ff = pin_in;
      nxt_q.sync2_ff = q_ff.sync1_ff;
      nxt_q.prev_sck_ff = q_ff.sync2_ff.sck;
      nxt_q.prev_ss_ff = q_ff.sync2_ff.ss;

      // clears first so that a same-cycle set wins
      if (flag_clr) begin
         nxt_q.flag_ff = 1'b0;
         nxt_q.overrun_ff = 1'b0;
      end
      if (rd_en) begin
         nxt_q.rx_full_ff = 1'b0;
      end
      if (master_set) begin
         nxt_q.master_ff = 1'b1;
      end

      // load of a new byte
      if (wr_valid && wr_ready) begin
         nxt_q.shreg_ff = wr_data;
         nxt_q.bitcnt_ff = '0;
         nxt_q.div_ff = '0;
         nxt_q.sck_ff = 1'b0;
         if (q_ff.master_ff) begin
            nxt_q.phase_ff = spms_pkg::ST_SHIFT;
         end
      end

      // master shift engine
      case (q_ff.phase_ff)
         spms_pkg::ST_IDLE: begin
            nxt_q.div_ff = '0;
         end
         spms_pkg::ST_SHIFT: begin
            if (q_ff.div_ff == DIV_LAST) begin
               nxt_q.div_ff = '0;
               nxt_q.sck_ff = ~q_ff.sck_ff;
               if (!q_ff.sck_ff) begin
                  nxt_q.rx_bit_ff = q_ff.sync2_ff.miso;
               end else begin
                  nxt_q.shreg_ff = shifted;
                  nxt_q.bitcnt_ff = q_ff.bitcnt_ff + 1'b1;
                  if (q_ff.bitcnt_ff == spms_pkg::LAST_BIT) begin
                     done = 1'b1;
                     nxt_q.bitcnt_ff = '0;
                     nxt_q.phase_ff = spms_pkg::ST_IDLE;
                  end
               end
            end else begin
               nxt_q.div_ff = q_ff.div_ff + 1'b1;
            end
         end
         default: begin
            nxt_q.phase_ff = spms_pkg::ST_IDLE;
         end
      endcase

      // slave shift engine, edges only seen while selected
      if (slave_act) begin
         if (sck_rise) begin
            nxt_q.rx_bit_ff = q_ff.sync2_ff.mosi;
         end
         if (sck_fall) begin
            nxt_q.shreg_ff = shifted;
            nxt_q.bitcnt_ff = q_ff.bitcnt_ff + 1'b1;
            if (q_ff.bitcnt_ff == spms_pkg::LAST_BIT) begin
               done = 1'b1;
               nxt_q.bitcnt_ff = '0;
            end
         end
      end

      // deselect during a slave byte drops both partial bytes
      // only mid-byte, so the idle-level jump after reset or enable is inert
      if (spi_en && !q_ff.master_ff && ss_rise &&
          (q_ff.bitcnt_ff != '0)) begin
         nxt_q.bitcnt_ff = '0;
         nxt_q.shreg_ff = spms_pkg::RST_BYTE;
      end

      // completed byte into the receive holding register
      if (done) begin
         nxt_q.rx_buf_ff = shifted;
         nxt_q.rx_full_ff = 1'b1;
         if (q_ff.rx_full_ff && !rd_en) begin
            nxt_q.overrun_ff = 1'b1;
         end
         nxt_q.flag_ff = 1'b1;
      end

      // forced demotion by another master
      if (demote) begin
         nxt_q.master_ff = 1'b0;
         nxt_q.phase_ff = spms_pkg::ST_IDLE;
         nxt_q.bitcnt_ff = '0;
         nxt_q.sck_ff = 1'b0;
         nxt_q.flag_ff = 1'b1;
      end

      if (!spi_en) begin
         nxt_q.phase_ff = spms_pkg::ST_IDLE;
         nxt_q.bitcnt_ff = '0;
         nxt_q.sck_ff = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_ff <= '0;
      end else if (ce) begin
         q_ff <= nxt_q;
      end
   end

   // ----------------------------------------------------------------
   // pin overrides
   // ----------------------------------------------------------------
   always_comb begin
      pin_out = pin_gpio;
      pin_oe = pin_dir;
      if (spi_en) begin
         pin_out.sck = q_ff.sck_ff;
         if (lsb_first) begin
            pin_out.mosi = q_ff.shreg_ff[0];
         end else begin
            pin_out.mosi = q_ff.shreg_ff[spms_pkg::DATA_W-1];
         end
         pin_out.miso = pin_out.mosi;
         pin_out.ss = pin_gpio.ss;
         if (q_ff.master_ff) begin
            pin_oe.miso = 1'b0;
         end else begin
            pin_oe.mosi = 1'b0;
            pin_oe.sck = 1'b0;
            pin_oe.ss = 1'b0;
            pin_oe.miso = pin_dir.miso & ss_low;
         end
      end
   end

   // ----------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------
   assign busy = (q_ff.phase_ff == spms_pkg::ST_SHIFT) |
                 (q_ff.bitcnt_ff != '0);
   assign wr_ready = spi_en & ~busy & ~demote;
   assign rd_data = q_ff.rx_buf_ff;
   assign rx_full = q_ff.rx_full_ff;
   assign master_select_bit = q_ff.master_ff;
   assign transfer_complete_flag = q_ff.flag_ff;
   assign overrun = q_ff.overrun_ff;
   assign irq = q_ff.flag_ff & spi_ie & global_ie;

endmodule // spms_core

// ==== dv/spms_partner.sv ====
// far-side slave model: shifts a fixed byte out, collects what it hears
`timescale 1ns/100ps
module spms_partner #(
   parameter logic [7:0] TX = 8'ha5
) (
   // link pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   output logic miso,
   output logic [7:0] got
);
   logic [2:0] idx = 3'd0;
   // bit position restarts whenever the far side is deselected
   always @(negedge sck or posedge ss_n) begin
      if (ss_n) begin
         idx <= 3'd0;
      end else begin
         idx <= idx + 3'd1;
      end
   end
   always @(posedge sck) begin
      if (!ss_n) begin
         got <= {got[6:0], mosi};
      end
   end
   // released line shows the inverse of the current bit
   assign miso = ss_n ? ~TX[3'd7 - idx] : TX[3'd7 - idx];
endmodule // spms_partner

// ==== dv/spms_core_assertions.sv ====
// checker: port relations of the spi master/slave core
`timescale 1ns/100ps
module spms_core_assertions (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic spi_en,
   input wire logic spi_ie,
   input wire logic global_ie,
   input wire logic master_set,
   input wire spms_pkg::spms_pins_t pin_dir,
   input wire spms_pkg::spms_pins_t pin_gpio,
   // status and pins
   input wire logic wr_ready,
   input wire logic rx_full,
   input wire logic master_select_bit,
   input wire logic transfer_complete_flag,
   input wire logic overrun,
   input wire logic busy,
   input wire logic irq,
   input wire spms_pkg::spms_pins_t pin_out,
   input wire spms_pkg::spms_pins_t pin_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_slave_pins_in: assert property (
      spi_en && !master_select_bit |-> !pin_oe.sck && !pin_oe.mosi
      && !pin_oe.ss) else $error("slave drives a forced input");
   a_master_miso_in: assert property (
      spi_en && master_select_bit |-> !pin_oe.miso)
      else $error("master drives miso");
   a_ss_gpio: assert property (
      spi_en && master_select_bit && pin_dir.ss |-> pin_oe.ss
      && pin_out.ss == pin_gpio.ss) else $error("ss not plain output");
   a_demote_flag: assert property (
      $fell(master_select_bit) |-> transfer_complete_flag)
      else $error("demotion without flag");
   a_demote_hold: assert property (
      !master_select_bit && !master_set |=> !master_select_bit)
      else $error("master bit set by itself");
   a_irq_level: assert property (
      irq == (transfer_complete_flag && spi_ie && global_ie))
      else $error("irq mismatch");
   a_one_byte: assert property (
      busy |-> !wr_ready) else $error("write accepted while busy");
   a_done_flag: assert property (
      $fell(busy) && master_select_bit |-> transfer_complete_flag)
      else $error("byte done without flag");
   a_overrun_cause: assert property (
      $rose(overrun) |-> $past(rx_full)) else $error("spurious overrun");
   cover property ($fell(master_select_bit));
   cover property ($rose(overrun));
   cover property ($fell(busy) && rx_full);
endmodule // spms_core_assertions
bind spms_core spms_core_assertions u_chk (.*);

// ==== dv/spms_core_test.sv ====
// testbench: pin overrides, slave, master and demotion scenarios
`timescale 1ns/100ps
module spms_core_test;
   logic clk = 0, rst = 1, ce = 1, spi_en = 0, spi_ie = 1, global_ie = 1;
   logic lsb_first = 0, master_set = 0, wr_valid = 0, rd_en = 0;
   logic flag_clr = 0, wr_ready, rx_full, master_select_bit, irq;
   logic transfer_complete_flag, overrun, busy, miso_far;
   logic [7:0] wr_data = 8'h00, rd_data, got;
   logic [7:0] heard = 8'h00;
   spms_pkg::spms_pins_t pin_dir = 4'hf, pin_gpio = 4'h0, ext = 4'h1;
   spms_pkg::spms_pins_t pin_in, pin_out, pin_oe;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   // ----------------------------------------------------------------
   // wire levels and instances
   // ----------------------------------------------------------------
   assign pin_in.sck = pin_oe.sck ? pin_out.sck : ext.sck;
   assign pin_in.mosi = pin_oe.mosi ? pin_out.mosi : ext.mosi;
   assign pin_in.miso = pin_oe.miso ? pin_out.miso : miso_far;
   assign pin_in.ss = pin_oe.ss ? pin_out.ss : ext.ss;
   spms_core #(.SCK_HALF(spms_pkg::SCK_HALF_CYC)) dut_u (.clk, .rst, .ce,
      .spi_en, .spi_ie,
      .global_ie, .lsb_first, .master_set, .pin_dir, .pin_gpio, .wr_valid,
      .wr_data, .wr_ready, .rd_en, .rd_data, .rx_full, .flag_clr,
      .master_select_bit, .transfer_complete_flag, .overrun, .busy, .irq,
      .pin_in, .pin_out, .pin_oe);
   spms_partner far_u (.sck(pin_in.sck), .mosi(pin_in.mosi),
      .ss_n(pin_in.ss), .miso(miso_far), .got(got));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         results();
      end
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (!ok) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic clr;
      @(posedge clk);
      rd_en <= 1'b1;
      flag_clr <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      flag_clr <= 1'b0;
   endtask
   // tb stands in for a far master, link period 130 ns
   task automatic sbits(input logic [7:0] d, input int n);
      int i;
      for (i = 7; i > 7 - n; i--) begin
         @(posedge clk);
         ext.mosi <= d[i];
         repeat (12) @(posedge clk);
         ext.sck <= 1'b1;
         heard <= {heard[6:0], pin_in.miso};
         repeat (13) @(posedge clk);
         ext.sck <= 1'b0;
      end
      wt(5);
   endtask
   task automatic mxfer(input logic [7:0] d);
      int i;
      @(posedge clk);
      wr_valid <= 1'b1;
      wr_data <= d;
      @(posedge clk);
      wr_data <= 8'hff;
      @(negedge clk);
      chk(wr_ready === 1'b0, "write open while busy");
      @(posedge clk);
      wr_valid <= 1'b0;
      for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
      wt(2);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_pins;
      @(negedge clk);
      chk(pin_oe === pin_dir, "disabled pins not gpio");
      @(posedge clk);
      spi_en <= 1'b1;
      wt(4);
      chk(pin_oe === 4'h0, "passive slave drives");
      @(posedge clk) ext.ss <= 1'b0;
      wt(4);
      chk(pin_oe === 4'h2, "active slave pins");
   endtask
   task automatic t_slave;
      @(posedge clk);
      ext.ss <= 1'b1;
      sbits(8'h5a, 8);
      chk(transfer_complete_flag === 1'b0, "passive slave took");
      @(posedge clk) ext.ss <= 1'b0;
      sbits(8'hff, 4);
      @(posedge clk) ext.ss <= 1'b1;
      wt(4);
      @(posedge clk);
      wr_valid <= 1'b1;
      wr_data <= 8'h69;
      @(posedge clk);
      wr_valid <= 1'b0;
      ext.ss <= 1'b0;
      sbits(8'h96, 8);
      chk(rd_data === 8'h96 && irq === 1'b1, "slave byte");
      chk(heard === 8'h69, "slave sent byte");
      @(posedge clk) ext.ss <= 1'b1;
      clr();
   endtask
   task automatic t_master;
      @(posedge clk);
      master_set <= 1'b1;
      @(posedge clk);
      master_set <= 1'b0;
      wt(4);
      chk(master_select_bit === 1'b1 && pin_oe === 4'hd, "master pins");
      chk(pin_out.ss === 1'b0, "ss gpio value");
      mxfer(8'h3c);
      chk(got === 8'h3c && rd_data === 8'ha5 && irq === 1'b1, "m1");
      chk(rx_full === 1'b1, "byte not held");
      mxfer(8'hc3);
      chk(got === 8'hc3 && overrun === 1'b1, "no overrun");
      clr();
      wt(1);
      chk(rx_full === 1'b0 && overrun === 1'b0, "not cleared");
   endtask
   task automatic t_demote;
      @(posedge clk);
      pin_gpio.ss <= 1'b1;
      wt(4);
      @(posedge clk);
      pin_dir.ss <= 1'b0;
      ext.ss <= 1'b1;
      wt(5);
      chk(master_select_bit === 1'b1, "demoted while ss high");
      @(posedge clk) ext.ss <= 1'b0;
      wt(6);
      chk(master_select_bit === 1'b0 && irq === 1'b1, "no demotion");
      chk(pin_oe.sck === 1'b0 && pin_oe.mosi === 1'b0, "still drives");
      @(posedge clk) ext.ss <= 1'b1;
      wt(10);
      chk(master_select_bit === 1'b0, "master came back");
      @(posedge clk) master_set <= 1'b1;
      @(posedge clk) master_set <= 1'b0;
      wt(1);
      chk(master_select_bit === 1'b1, "master not set");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_pins();
      t_slave();
      t_master();
      t_demote();
      results();
   end
endmodule // spms_core_test
